// [src/arpc_pkg.sv]
package arpc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h1c;
  localparam logic [7:0] ADDR_BUF0    = 8'h20;
  localparam logic [7:0] ADDR_BUF1    = 8'h24;
  localparam logic [7:0] ADDR_BUF2    = 8'h28;
  localparam logic [7:0] ADDR_BUF3    = 8'h2c;
  localparam logic [7:0] ADDR_EVT_STS = 8'h30;
  localparam logic [7:0] ADDR_EVT_MSK = 8'h34;
  localparam int         ADDR_W       = 8;

  // Control word field positions
  localparam int CTRL_BATCH_HI = 31;
  localparam int CTRL_BATCH_LO = 30;
  localparam int CTRL_TRIM_HI  = 29;
  localparam int CTRL_TRIM_LO  = 26;
  localparam int CTRL_FLAG     = 9;
  localparam int CTRL_GAIN_EN  = 8;
  localparam int CTRL_GAIN_HI  = 7;
  localparam int CTRL_GAIN_LO  = 3;
  localparam int CTRL_HP_EN    = 2;
  localparam int CTRL_REC_EN   = 1;
  localparam int CTRL_FILT_RST = 0;

  // Event status / mask bit positions
  localparam int EVT_BATCH   = 0;
  localparam int EVT_REFUSED = 1;
  localparam int EVT_W       = 2;

  // Reset values
  localparam logic [31:0]      CTRL_RESET = 32'h0000_0000;
  localparam logic [EVT_W-1:0] EVT_RESET  = 2'h0;

  // Sample buffer geometry and batch pacing
  localparam int SAMPLE_W   = 16;
  localparam int SLOT_COUNT = 8;
  localparam int SLOT_W     = 3;

  // Record control fields as held in the block
  typedef struct packed {
    logic [1:0] batch_size_select;
    logic [3:0] engineering_trim;
    logic       batch_done_flag;
    logic       gain_path_enable;
    logic [4:0] record_gain;
    logic       highpass_enable;
    logic       record_enable;
    logic       filter_reset;
  } arpc_ctrl_t;

  // A sample with its strobe
  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] data;
  } arpc_sample_t;

endpackage

// [src/arpc_record_ctrl.sv]
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module arpc_record_ctrl #(
  parameter int DECIM_LOG2 = 2,
  parameter int HP_SHIFT   = 6
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [arpc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Converter side
  input  wire arpc_pkg::arpc_sample_t        raw_sample,
  input  wire logic [2:0]                    channel_select,
  input  wire logic                          norm_conv_req,
  output logic [2:0]                         adc_input_sel,
  output logic                               differential_mode,
  output logic                               normal_conv_block,
  output logic                               gain_path_enable,
  output logic                               record_path_enable,
  output logic [4:0]                         record_gain,
  output logic [3:0]                         engineering_trim,
  output logic                               irq
);

  localparam int SW = arpc_pkg::SAMPLE_W;

  // Reset image of the held fields: control bits 31 to 26 above bits 9 to 0
  localparam logic [15:0] CTRL_INIT = {
    arpc_pkg::CTRL_RESET[arpc_pkg::CTRL_BATCH_HI:arpc_pkg::CTRL_TRIM_LO],
    arpc_pkg::CTRL_RESET[arpc_pkg::CTRL_FLAG:arpc_pkg::CTRL_FILT_RST]
  };

  // Elaboration-time parameter check
  if (DECIM_LOG2 < 0 || DECIM_LOG2 > 8) begin : g_bad_decim
    $error("DECIM_LOG2 must be 0 to 8");
  end
  if (HP_SHIFT < 1 || HP_SHIFT > 14) begin : g_bad_hp
    $error("HP_SHIFT must be 1 to 14");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state
  arpc_pkg::arpc_ctrl_t              ctrl_q;
  logic [arpc_pkg::EVT_W-1:0]        evt_sts_q;
  logic [arpc_pkg::EVT_W-1:0]        evt_msk_q;
  logic signed [SW-1:0]              slot_q [arpc_pkg::SLOT_COUNT];
  logic [arpc_pkg::SLOT_W-1:0]       slot_idx_q;
  logic [7:0]                        dec_cnt_q;
  logic signed [SW+8:0]              dec_acc_q;
  arpc_pkg::arpc_sample_t            dec_q;
  logic signed [SW-1:0]              hp_x_prev_q;
  logic signed [SW+1:0]              hp_y_prev_q;
  arpc_pkg::arpc_sample_t            rec_q;
  logic [31:0]                       rdata_d;
  logic                              unmapped_d;
  logic                              pready_q;
  logic [31:0]                       prdata_q;
  logic                              pslverr_q;
  logic                              wr_commit;
  logic                              flt_hold;
  logic                              batch_end;
  logic [arpc_pkg::SLOT_W-1:0]       batch_last;
  logic                              flag_clr;
  logic                              refused_evt;
  logic signed [SW+8:0]              dec_sum;
  logic signed [SW+1:0]              hp_y;
  logic signed [SW+1:0]              sat_src;
  logic signed [SW-1:0]              rec_data_d;
  logic [arpc_pkg::EVT_W-1:0]        evt_set;
  logic [arpc_pkg::EVT_W-1:0]        evt_clr;

  ////////////////////////////////////////////////////////////////////////////////
  // APB access: one wait state, write commits at the edge pready is seen high
  assign wr_commit = psel && penable && pready_q && pwrite;

  // Read mux and address decode
  always_comb begin
    rdata_d    = 32'h0000_0000;
    unmapped_d = 1'b0;
    unique case (paddr)
      arpc_pkg::ADDR_CTRL: begin
        rdata_d[arpc_pkg::CTRL_BATCH_HI:arpc_pkg::CTRL_BATCH_LO] = ctrl_q.batch_size_select;
        rdata_d[arpc_pkg::CTRL_TRIM_HI:arpc_pkg::CTRL_TRIM_LO]   = ctrl_q.engineering_trim;
        rdata_d[arpc_pkg::CTRL_FLAG]                             = ctrl_q.batch_done_flag;
        rdata_d[arpc_pkg::CTRL_GAIN_EN]                          = ctrl_q.gain_path_enable;
        rdata_d[arpc_pkg::CTRL_GAIN_HI:arpc_pkg::CTRL_GAIN_LO]   = ctrl_q.record_gain;
        rdata_d[arpc_pkg::CTRL_HP_EN]                            = ctrl_q.highpass_enable;
        rdata_d[arpc_pkg::CTRL_REC_EN]                           = ctrl_q.record_enable;
        rdata_d[arpc_pkg::CTRL_FILT_RST]                         = ctrl_q.filter_reset;
      end
      arpc_pkg::ADDR_BUF0, arpc_pkg::ADDR_BUF1, arpc_pkg::ADDR_BUF2, arpc_pkg::ADDR_BUF3: begin
        // Word k holds slot 2k low and slot 2k+1 high
        rdata_d = {slot_q[{paddr[3:2], 1'b1}], slot_q[{paddr[3:2], 1'b0}]};
      end
      arpc_pkg::ADDR_EVT_STS: rdata_d[arpc_pkg::EVT_W-1:0] = evt_sts_q;
      arpc_pkg::ADDR_EVT_MSK: rdata_d[arpc_pkg::EVT_W-1:0] = evt_msk_q;
      default:                unmapped_d = 1'b1;
    endcase
  end

  // Answer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q  <= 1'b1;
      prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr_q <= unmapped_d;
    end else begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control word
  assign flag_clr = wr_commit && (paddr == arpc_pkg::ADDR_CTRL) && !pwdata[arpc_pkg::CTRL_FLAG];

  // Writable fields; flag is set by a batch end, cleared by writing 0, set wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= arpc_pkg::arpc_ctrl_t'(CTRL_INIT);
    end else begin
      if (wr_commit && paddr == arpc_pkg::ADDR_CTRL) begin
        ctrl_q.batch_size_select <= pwdata[arpc_pkg::CTRL_BATCH_HI:arpc_pkg::CTRL_BATCH_LO];
        ctrl_q.engineering_trim  <= pwdata[arpc_pkg::CTRL_TRIM_HI:arpc_pkg::CTRL_TRIM_LO];
        ctrl_q.gain_path_enable  <= pwdata[arpc_pkg::CTRL_GAIN_EN];
        ctrl_q.record_gain       <= pwdata[arpc_pkg::CTRL_GAIN_HI:arpc_pkg::CTRL_GAIN_LO];
        ctrl_q.highpass_enable   <= pwdata[arpc_pkg::CTRL_HP_EN];
        ctrl_q.record_enable     <= pwdata[arpc_pkg::CTRL_REC_EN];
        ctrl_q.filter_reset      <= pwdata[arpc_pkg::CTRL_FILT_RST];
      end
      if (batch_end) begin
        ctrl_q.batch_done_flag <= 1'b1;
      end else if (flag_clr) begin
        ctrl_q.batch_done_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decimation: average 2**DECIM_LOG2 raw samples, cleared while disabled or in filter reset
  assign flt_hold = ctrl_q.filter_reset || !ctrl_q.record_enable;
  assign dec_sum  = dec_acc_q + (SW+9)'(raw_sample.data);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_cnt_q <= 8'h00;
      dec_acc_q <= '0;
      dec_q     <= '0;
    end else if (flt_hold) begin
      dec_cnt_q <= 8'h00;
      dec_acc_q <= '0;
      dec_q     <= '0;
    end else begin
      dec_q.valid <= 1'b0;
      if (raw_sample.valid) begin
        if (dec_cnt_q == 8'((1 << DECIM_LOG2) - 1)) begin
          dec_cnt_q  <= 8'h00;
          dec_acc_q  <= '0;
          dec_q.valid <= 1'b1;
          dec_q.data  <= SW'(dec_sum >>> DECIM_LOG2);
        end else begin
          dec_cnt_q <= dec_cnt_q + 8'h01;
          dec_acc_q <= dec_sum;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // High-pass: y = x - x_prev + y_prev - y_prev/2**HP_SHIFT, saturated to 16 bits
  assign hp_y = (SW+2)'(dec_q.data) - (SW+2)'(hp_x_prev_q) + hp_y_prev_q
              - (hp_y_prev_q >>> HP_SHIFT);
  assign sat_src = ctrl_q.highpass_enable ? hp_y : (SW+2)'(dec_q.data);

  // Saturation keeps the result a valid two's complement sample
  always_comb begin
    if (sat_src > (SW+2)'(32767)) begin
      rec_data_d = 16'sh7fff;
    end else if (sat_src < -(SW+2)'(32768)) begin
      rec_data_d = 16'sh8000;
    end else begin
      rec_data_d = SW'(sat_src);
    end
  end

  // Filter history and recorded sample strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hp_x_prev_q <= '0;
      hp_y_prev_q <= '0;
      rec_q       <= '0;
    end else if (flt_hold) begin
      hp_x_prev_q <= '0;
      hp_y_prev_q <= '0;
      rec_q       <= '0;
    end else begin
      rec_q.valid <= dec_q.valid;
      if (dec_q.valid) begin
        hp_x_prev_q <= dec_q.data;
        hp_y_prev_q <= ctrl_q.highpass_enable ? (SW+2)'(rec_data_d) : '0;
        rec_q.data  <= rec_data_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample buffer and batch pacing
  assign batch_last = arpc_pkg::SLOT_W'((1 << ctrl_q.batch_size_select) - 1);
  assign batch_end  = rec_q.valid && !flt_hold && (slot_idx_q == batch_last);

  // Slot index walks up from 0 and returns to 0 after each batch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_idx_q <= '0;
    end else if (flt_hold) begin
      slot_idx_q <= '0;
    end else if (batch_end) begin
      slot_idx_q <= '0;
    end else if (rec_q.valid) begin
      slot_idx_q <= slot_idx_q + 3'h1;
    end
  end

  // Slot storage, written only by the recording path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < arpc_pkg::SLOT_COUNT; i++) begin
        slot_q[i] <= '0;
      end
    end else if (rec_q.valid && !flt_hold) begin
      slot_q[slot_idx_q] <= rec_q.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event status (write 1 to clear, set wins) and mask
  assign refused_evt = norm_conv_req && (ctrl_q.gain_path_enable || ctrl_q.record_enable);
  assign evt_set     = {refused_evt, batch_end};
  assign evt_clr     = (wr_commit && paddr == arpc_pkg::ADDR_EVT_STS) ?
                       pwdata[arpc_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_sts_q <= arpc_pkg::EVT_RESET;
    end else begin
      evt_sts_q <= (evt_sts_q & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_msk_q <= arpc_pkg::EVT_RESET;
    end else if (wr_commit && paddr == arpc_pkg::ADDR_EVT_MSK) begin
      evt_msk_q <= pwdata[arpc_pkg::EVT_W-1:0];
    end
  end

  // Interrupt: the flag always raises it, other events through the mask
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= ctrl_q.batch_done_flag || (|(evt_sts_q & evt_msk_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_input_sel      <= 3'h0;
      differential_mode  <= 1'b0;
      normal_conv_block  <= 1'b0;
      gain_path_enable   <= 1'b0;
      record_path_enable <= 1'b0;
      record_gain        <= 5'h00;
      engineering_trim   <= 4'h0;
    end else begin
      adc_input_sel      <= ctrl_q.record_enable ? 3'h0 : channel_select;
      differential_mode  <= ctrl_q.record_enable;
      normal_conv_block  <= ctrl_q.gain_path_enable || ctrl_q.record_enable;
      gain_path_enable   <= ctrl_q.gain_path_enable;
      record_path_enable <= ctrl_q.gain_path_enable;
      record_gain        <= ctrl_q.record_gain;
      engineering_trim   <= ctrl_q.engineering_trim; // Software keeps it zero
    end
  end

endmodule

// [sim/arpc_adc_model.sv]
`timescale 1ns/1ps
module arpc_adc_model (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             go,
  input  wire logic [15:0]      din,
  output arpc_pkg::arpc_sample_t raw_sample
);
  // One converted sample per request; data is not held outside the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_sample <= '0;
    end else if (go) begin
      raw_sample.valid <= 1'b1;
      raw_sample.data  <= din;
    end else begin
      raw_sample.valid <= 1'b0;
      raw_sample.data  <= ~raw_sample.data;
    end
  end
endmodule

// [sim/arpc_record_ctrl_chk.sv]
`timescale 1ns/1ps
module arpc_record_ctrl_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  adc_input_sel,
  input wire logic        differential_mode,
  input wire logic        normal_conv_block,
  input wire logic        gain_path_enable,
  input wire logic        record_path_enable,
  input wire logic [4:0]  record_gain,
  input wire logic [3:0]  engineering_trim
);
  logic wr_ctrl;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Committed write to the control word
  assign wr_ctrl = psel && penable && pready && pwrite && (paddr == arpc_pkg::ADDR_CTRL);
  property p_gain;
    wr_ctrl |-> ##2 record_gain == $past(pwdata[7:3], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not from control");
  property p_trim;
    wr_ctrl |-> ##2 engineering_trim == $past(pwdata[29:26], 2);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not from control");
  property p_path;
    wr_ctrl |-> ##2 gain_path_enable == $past(pwdata[8], 2);
  endproperty
  a_path: assert property (p_path) else $error("path enable wrong");
  property p_paths_eq;
    gain_path_enable == record_path_enable;
  endproperty
  a_paths_eq: assert property (p_paths_eq) else $error("paths differ");
  property p_rec;
    wr_ctrl |-> ##2 differential_mode == $past(pwdata[1], 2);
  endproperty
  a_rec: assert property (p_rec) else $error("record enable wrong");
  property p_block;
    wr_ctrl |-> ##2 normal_conv_block == ($past(pwdata[8], 2) | $past(pwdata[1], 2));
  endproperty
  a_block: assert property (p_block) else $error("conversion block wrong");
  property p_sel;
    differential_mode |-> adc_input_sel == 3'h0;
  endproperty
  a_sel: assert property (p_sel) else $error("channel select used");
  property p_ready;
    pready |-> $past(penable) && !$past(pready) ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready timing wrong");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rdzero;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdzero: assert property (p_rdzero) else $error("read data outside answer");
endmodule
bind arpc_record_ctrl arpc_record_ctrl_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_input_sel(adc_input_sel), .differential_mode(differential_mode),
  .normal_conv_block(normal_conv_block), .gain_path_enable(gain_path_enable),
  .record_path_enable(record_path_enable), .record_gain(record_gain),
  .engineering_trim(engineering_trim)
);

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  logic                   core_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0, prdata;
  logic                   pready, pslverr, norm_conv_req = 1'b0, irq;
  logic [2:0]             channel_select = 3'h0, adc_input_sel;
  logic [15:0]            din = 16'h0;
  logic                   differential_mode, normal_conv_block, gain_path_enable, record_path_enable;
  logic [4:0]             record_gain, gain = 5'h0;
  logic [3:0]             engineering_trim;
  arpc_pkg::arpc_sample_t raw_sample;
  int                     failures = 0, checks = 0, cycles = 0, xp = 0, yp = 0;
  logic [32:0]            exp_q[$];
  logic [15:0]            slot_m[8] = '{default: 16'h0};

  always #5 core_clk = ~core_clk;

  arpc_adc_model adc (.core_clk(core_clk), .rst_n(rst_n), .go(go), .din(din),
    .raw_sample(raw_sample));
  arpc_record_ctrl #(.DECIM_LOG2(0), .HP_SHIFT(6)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_sample(raw_sample),
    .channel_select(channel_select), .norm_conv_req(norm_conv_req),
    .adc_input_sel(adc_input_sel), .differential_mode(differential_mode),
    .normal_conv_block(normal_conv_block), .gain_path_enable(gain_path_enable),
    .record_path_enable(record_path_enable), .record_gain(record_gain),
    .engineering_trim(engineering_trim), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    checks++;
    if (seen !== expv) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read answers are compared against the oldest note
  always @(posedge core_clk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front());
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB master: hold the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic smp(input logic [15:0] x);
    din <= x;
    go <= 1'b1;
    channel_select <= 3'($urandom);
    @(posedge core_clk);
    go <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  // Control word with reserved bits set; they must read back 0
  function automatic logic [31:0] cw(input logic [1:0] s, input logic h, input logic r,
                                     input logic f);
    return {s, 4'h0, 16'hffff, 1'b0, 1'b1, gain, h, r, f};
  endfunction

  function automatic logic [15:0] hpf(input int x);
    int y;
    y = x - xp + yp - (yp >>> 6);
    if (y > 32767) y = 32767;
    if (y < -32768) y = -32768;
    xp = x;
    yp = y;
    return 16'(y);
  endfunction

  task automatic run_batch(input int n, input logic [31:0] c);
    logic [15:0] x;
    wr_c: apb(1'b1, arpc_pkg::ADDR_CTRL, c);
    for (int k = 0; k < n; k++) begin
      if (k == n - 1) rd(arpc_pkg::ADDR_EVT_STS, 33'h0);
      x = 16'($urandom);
      slot_m[k] = c[2] ? hpf($signed(x)) : x;
      smp(x);
    end
    check(irq, 1'b1);
    rd(arpc_pkg::ADDR_CTRL, {1'b0, (c & 32'hc00003ff) | 32'h200});
    rd(arpc_pkg::ADDR_EVT_STS, 33'h1);
    for (int w = 0; w < 4; w++)
      rd(arpc_pkg::ADDR_BUF0 + 8'(4 * w), {1'b0, slot_m[2 * w + 1], slot_m[2 * w]});
    apb(1'b1, arpc_pkg::ADDR_CTRL, c);
    apb(1'b1, arpc_pkg::ADDR_EVT_STS, 32'h1);
    rd(arpc_pkg::ADDR_CTRL, {1'b0, c & 32'hc00003ff});
    check(irq, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8ffb));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Reset values, read-only buffers, unmapped address
    apb(1'b1, arpc_pkg::ADDR_BUF3, $urandom);
    for (int a = 8'h1c; a <= 8'h34; a += 4) rd(8'(a), 33'h0);
    rd(8'h00, {1'b1, 32'h0});
    // Every batch size, back to back
    for (int s = 0; s < 4; s++) begin
      gain = 5'($urandom);
      run_batch(1 << s, cw(2'(s), 1'b0, 1'b1, 1'b0));
    end
    // Partial batch, then hold and record off drop samples and restart the count
    apb(1'b1, arpc_pkg::ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, 1'b0));
    repeat (3) smp(16'($urandom));
    apb(1'b1, arpc_pkg::ADDR_CTRL, cw(2'h3, 1'b0, 1'b1, 1'b1));
    smp(16'h1234);
    apb(1'b1, arpc_pkg::ADDR_CTRL, cw(2'h3, 1'b0, 1'b0, 1'b0));
    smp(16'h4321);
    rd(arpc_pkg::ADDR_EVT_STS, 33'h0);
    run_batch(8, cw(2'h3, 1'b0, 1'b1, 1'b0));
    // High-pass filter from a cleared history
    apb(1'b1, arpc_pkg::ADDR_CTRL, cw(2'h1, 1'b1, 1'b1, 1'b1));
    xp = 0;
    yp = 0;
    run_batch(2, cw(2'h1, 1'b1, 1'b1, 1'b0));
    // Refused conversion event, masked then unmasked, then cleared
    norm_conv_req <= 1'b1;
    @(posedge core_clk);
    norm_conv_req <= 1'b0;
    rd(arpc_pkg::ADDR_EVT_STS, 33'h2);
    check(irq, 1'b0);
    apb(1'b1, arpc_pkg::ADDR_EVT_MSK, 32'h3);
    rd(arpc_pkg::ADDR_EVT_MSK, 33'h3);
    check(irq, 1'b1);
    apb(1'b1, arpc_pkg::ADDR_EVT_STS, 32'h2);
    rd(arpc_pkg::ADDR_EVT_STS, 33'h0);
    check(irq, 1'b0);
    summarize();
  end
endmodule
